// ===== src/tcu_pkg.sv
package tcu_pkg;

  // register byte addresses
  localparam logic [7:0] TCU_OFS_CONTROL = 8'h00;
  localparam logic [7:0] TCU_OFS_CAP_LOW = 8'h04;
  localparam logic [7:0] TCU_OFS_CAP_HIGH = 8'h08;
  localparam logic [7:0] TCU_OFS_FLAG = 8'h0C;
  localparam logic [7:0] TCU_OFS_ENABLE = 8'h10;
  localparam logic [7:0] TCU_OFS_ALT_PIN = 8'h14;

  // control field positions
  localparam int TCU_MODE_LSB = 0;
  localparam int TCU_TSEL_BIT = 4;

  // capture mode encodings of the mode field
  localparam logic [3:0] TCU_MODE_OFF = 4'h0;
  localparam logic [3:0] TCU_MODE_FALL = 4'h4;
  localparam logic [3:0] TCU_MODE_RISE = 4'h5;
  localparam logic [3:0] TCU_MODE_RISE4 = 4'h6;
  localparam logic [3:0] TCU_MODE_RISE16 = 4'h7;

  // prescaler terminal counts
  localparam logic [3:0] TCU_PS4_LAST = 4'h3;
  localparam logic [3:0] TCU_PS16_LAST = 4'hF;

  // reset values
  localparam logic [5:0] TCU_CONTROL_RST = 6'h00;
  localparam logic [15:0] TCU_CAPTURE_RST = 16'h0000;
  localparam logic [3:0] TCU_PRESC_RST = 4'h0;

  // bus read wait states
  localparam int TCU_READ_WAIT = 1;

endpackage

// ===== src/tcu_capture.sv
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tcu_capture
  import tcu_pkg::*;
#(
  parameter int UNIT_NUM = 1
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // capture pads and time bases
  input  wire logic        capture_input_pin,
  input  wire logic        capture_input_pin_alt,
  input  wire logic [15:0] timer1_count,
  input  wire logic [15:0] timer3_count,
  input  wire logic [15:0] timer5_count,
  input  wire logic        sleep,
  input  wire logic        timer_ext_clock,
  output logic             timer_run_en,
  output logic             capture_irq_flag,
  output logic             capture_irq_enable,
  output logic             capture_strobe
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    // pad synchroniser, oldest sample in bit 2
    logic [2:0]  pin_sync;
    // software registers
    logic [5:0]  unit_control_reg;
    logic        unit2_pin_select;
    // capture result and interrupt
    logic [15:0] capture_value;
    logic        capture_irq_flag;
    logic        capture_irq_enable;
    logic [3:0]  presc_cnt;
    logic        strobe;
    // bus data phase tracking
    logic        ap_write;
    logic        ap_read;
    logic [7:0]  ap_addr;
    logic        rd_wait;
    logic [31:0] rdata;
  } tcu_state_t;

  tcu_state_t st_q;
  tcu_state_t st_d;

  logic [3:0]  unit_mode_field;
  logic        pin_level;
  logic        rise;
  logic        fall;
  logic        capture_mode;
  logic        event_hit;
  logic [15:0] timer_count_pair;
  logic        addr_phase;
  // register decode
  logic        wr_control;
  logic        wr_flag;
  logic        wr_enable;
  logic        wr_alt_pin;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////
  // combinational helpers

  // select pad; only unit two has an alternate pad
  always_comb begin
    unit_mode_field = st_q.unit_control_reg[TCU_MODE_LSB +: 4];
    pin_level = capture_input_pin;
    if (UNIT_NUM == 2 && st_q.unit2_pin_select) begin
      pin_level = capture_input_pin_alt;
    end
  end

  // select time base: low units pair timer 1 with 3, high units with 5
  always_comb begin
    if (!st_q.unit_control_reg[TCU_TSEL_BIT]) begin
      timer_count_pair = timer1_count;
    end else if (UNIT_NUM <= 5) begin
      timer_count_pair = timer3_count;
    end else begin
      timer_count_pair = timer5_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad edges

  // edges from differing second and third sync stages
  assign rise = st_q.pin_sync[1] & ~st_q.pin_sync[2];
  assign fall = ~st_q.pin_sync[1] & st_q.pin_sync[2];
  // bus address phase presented to this slave
  assign addr_phase = hsel & hready & htrans[1];

  ////////////////////////////////////////////////////////////////////////
  // mode and register decode

  // capture modes; every other code leaves the unit idle
  always_comb begin
    capture_mode = 1'b0;
    case (unit_mode_field)
      TCU_MODE_FALL: begin
        capture_mode = 1'b1;
      end
      TCU_MODE_RISE: begin
        capture_mode = 1'b1;
      end
      TCU_MODE_RISE4: begin
        capture_mode = 1'b1;
      end
      TCU_MODE_RISE16: begin
        capture_mode = 1'b1;
      end
      default: begin
        capture_mode = 1'b0;
      end
    endcase
  end

  // write strobes per register in the data phase
  always_comb begin
    wr_control = 1'b0;
    wr_flag = 1'b0;
    wr_enable = 1'b0;
    wr_alt_pin = 1'b0;
    if (st_q.ap_write) begin
      if (st_q.ap_addr == TCU_OFS_CONTROL) begin
        wr_control = 1'b1;
      end else if (st_q.ap_addr == TCU_OFS_FLAG) begin
        wr_flag = 1'b1;
      end else if (st_q.ap_addr == TCU_OFS_ENABLE) begin
        wr_enable = 1'b1;
      end else if (st_q.ap_addr == TCU_OFS_ALT_PIN) begin
        wr_alt_pin = 1'b1;
      end
    end
  end

  // read word of the addressed register, zero when unmapped
  always_comb begin
    rd_word = 32'h0000_0000;
    if (st_q.ap_addr == TCU_OFS_CONTROL) begin
      rd_word[5:0] = st_q.unit_control_reg;
    end else if (st_q.ap_addr == TCU_OFS_CAP_LOW) begin
      rd_word[7:0] = st_q.capture_value[7:0];
    end else if (st_q.ap_addr == TCU_OFS_CAP_HIGH) begin
      rd_word[7:0] = st_q.capture_value[15:8];
    end else if (st_q.ap_addr == TCU_OFS_FLAG) begin
      rd_word[0] = st_q.capture_irq_flag;
    end else if (st_q.ap_addr == TCU_OFS_ENABLE) begin
      rd_word[0] = st_q.capture_irq_enable;
    end else if (st_q.ap_addr == TCU_OFS_ALT_PIN) begin
      rd_word[0] = st_q.unit2_pin_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    // hold everything unless changed below
    st_d = st_q;
    event_hit = 1'b0;
    st_d.strobe = 1'b0;
    // pad seen whatever its direction
    st_d.pin_sync = {st_q.pin_sync[1:0], pin_level};

    // event qualification and prescaler
    case (unit_mode_field)
      TCU_MODE_FALL: begin
        event_hit = fall;
      end
      TCU_MODE_RISE: begin
        event_hit = rise;
      end
      // count rising edges, capture on the terminal one
      TCU_MODE_RISE4: begin
        if (rise) begin
          if (st_q.presc_cnt >= TCU_PS4_LAST) begin
            event_hit = 1'b1;
            st_d.presc_cnt = TCU_PRESC_RST;
          end else begin
            st_d.presc_cnt = st_q.presc_cnt + 4'h1;
          end
        end
      end
      // same with the longer terminal count
      TCU_MODE_RISE16: begin
        if (rise) begin
          if (st_q.presc_cnt >= TCU_PS16_LAST) begin
            event_hit = 1'b1;
            st_d.presc_cnt = TCU_PRESC_RST;
          end else begin
            st_d.presc_cnt = st_q.presc_cnt + 4'h1;
          end
        end
      end
      default: begin
        st_d.presc_cnt = TCU_PRESC_RST;
      end
    endcase

    // bus write in data phase
    if (wr_control) begin
      st_d.unit_control_reg = hwdata[5:0];
    end
    if (wr_flag) begin
      st_d.capture_irq_flag = hwdata[0];
    end
    if (wr_enable) begin
      st_d.capture_irq_enable = hwdata[0];
    end
    if (wr_alt_pin) begin
      st_d.unit2_pin_select = hwdata[0];
    end

    // capture latches whole count, overwriting older value
    if (event_hit && capture_mode) begin
      st_d.capture_value = timer_count_pair;
      st_d.capture_irq_flag = 1'b1;
      st_d.strobe = 1'b1;
    end

    // read path: one wait state, data from flops
    if (st_q.ap_read) begin
      st_d.rd_wait = 1'b1;
      st_d.ap_read = 1'b0;
      st_d.rdata = rd_word;
    end else if (st_q.rd_wait) begin
      st_d.rd_wait = 1'b0;
    end

    // address phase capture
    st_d.ap_write = 1'b0;
    if (addr_phase && hreadyout) begin
      st_d.ap_write = hwrite;
      st_d.ap_read = ~hwrite;
      st_d.ap_addr = {haddr[7:2], 2'b00};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // synchronous reset; clock enable freezes all state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      // pad and software registers
      st_q.pin_sync <= 3'h0;
      st_q.unit_control_reg <= TCU_CONTROL_RST;
      st_q.unit2_pin_select <= 1'b0;
      // capture result, flag and prescaler
      st_q.capture_value <= TCU_CAPTURE_RST;
      st_q.capture_irq_flag <= 1'b0;
      st_q.capture_irq_enable <= 1'b0;
      st_q.presc_cnt <= TCU_PRESC_RST;
      st_q.strobe <= 1'b0;
      // bus state
      st_q.ap_write <= 1'b0;
      st_q.ap_read <= 1'b0;
      st_q.ap_addr <= 8'h00;
      st_q.rd_wait <= 1'b0;
      st_q.rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // stall while read data is being fetched
  assign hreadyout = ~st_q.ap_read;
  // every transfer answers okay
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;

  // capture side outputs straight from flops
  assign capture_irq_flag = st_q.capture_irq_flag;
  assign capture_irq_enable = st_q.capture_irq_enable;
  assign capture_strobe = st_q.strobe;

  // instruction-clocked timer halts in sleep, external one runs on
  assign timer_run_en = ~sleep | timer_ext_clock;

endmodule

`default_nettype wire

// ===== tb/tcu_props.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_props (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sleep,
  input wire logic        timer_ext_clock,
  input wire logic        timer_run_en,
  input wire logic        capture_irq_flag,
  input wire logic        capture_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic wr_flag;
  // address phase of a software write to the flag register
  assign wr_flag = hsel & hready & htrans[1] & hwrite & clk_en & (haddr[7:2] == 6'h03);
  property p_flag_set; capture_strobe |-> capture_irq_flag; endproperty
  a_flag_set: assert property (p_flag_set) else $error("strobe without flag");
  property p_flag_cause; $rose(capture_irq_flag) |-> capture_strobe; endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag rose without strobe");
  property p_one_strobe; capture_strobe |=> !capture_strobe; endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobe longer than one cycle");
  property p_flag_hold; $fell(capture_irq_flag) |-> $past(wr_flag, 2); endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without write");
  property p_run_en; timer_run_en == (!sleep || timer_ext_clock); endproperty
  a_run_en: assert property (p_run_en) else $error("timer enable wrong");
  property p_rst; disable iff (1'b0) !rst_b |=> !capture_irq_flag && !capture_strobe; endproperty
  a_rst: assert property (p_rst) else $error("reset left flag or strobe");
  property p_rd_wait;
    hsel & hready & htrans[1] & !hwrite & hreadyout & clk_en |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
endmodule
bind tcu_capture tcu_props u_props (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sleep(sleep),
  .timer_ext_clock(timer_ext_clock), .timer_run_en(timer_run_en), .capture_irq_flag(capture_irq_flag),
  .capture_strobe(capture_strobe));
`default_nettype wire

// ===== tb/tcu_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_src (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       go,
  input wire logic [2:0] hold,
  output logic           pin
);
  logic [2:0] cnt_q;
  // pulse length counter; the pad idles low between events
  always_ff @(posedge clock) begin
    if (!rst_b) cnt_q <= 3'h0;
    else if (go) cnt_q <= hold;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  assign pin = (cnt_q != 3'h0);
endmodule
`default_nettype wire

// ===== tb/tb_timer_capture_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_capture_unit;
  import tcu_pkg::*;
  logic clock, rst_b, hsel, hwrite, go_m, go_a, pin_m, pin_a, sleep, ext, hreadyout, hresp, run_en, flag, ien, strobe;
  logic ce;
  logic [1:0] htrans;
  logic [7:0] haddr;
  logic [2:0] hold;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] t1, t3, t5, exp_v, v;
  integer seed = 4;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  tcu_capture #(.UNIT_NUM(2)) u_dut (.clock(clock), .rst_b(rst_b), .clk_en(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .capture_input_pin(pin_m), .capture_input_pin_alt(pin_a), .timer1_count(t1),
    .timer3_count(t3), .timer5_count(t5), .sleep(sleep), .timer_ext_clock(ext), .timer_run_en(run_en),
    .capture_irq_flag(flag), .capture_irq_enable(ien), .capture_strobe(strobe));
  tcu_pin_src u_src_m (.clock(clock), .rst_b(rst_b), .go(go_m), .hold(hold), .pin(pin_m));
  tcu_pin_src u_src_a (.clock(clock), .rst_b(rst_b), .go(go_a), .hold(hold), .pin(pin_a));
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////
  // expectation helpers and bus tasks
  function automatic logic [15:0] tsel_cnt(input logic s);
    return s ? t3 : t1;
  endfunction
  function automatic int edges(input logic [3:0] m);
    return (m == TCU_MODE_RISE4) ? 4 : (m == TCU_MODE_RISE16) ? 16 : 1;
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    samples_checked++;
    if (got !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cap(input logic [15:0] e);
    bus(1'b0, TCU_OFS_CAP_LOW, 32'h0);
    v[7:0] = rd[7:0];
    bus(1'b0, TCU_OFS_CAP_HIGH, 32'h0);
    v[15:8] = rd[7:0];
    chk({16'h0000, v}, {16'h0000, e});
  endtask
  // random timer values held steady, then one pad pulse
  task automatic pulse(input logic alt);
    t1 <= 16'($random(seed));
    t3 <= 16'($random(seed));
    t5 <= 16'($random(seed));
    hold <= 3'h2 + 3'($random(seed) & 3);
    go_m <= !alt;
    go_a <= alt;
    @(posedge clock);
    go_m <= 1'b0;
    go_a <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_b, hsel, hwrite, go_m, go_a, sleep, ext, htrans, haddr, hwdata} = '0;
    {t1, t3, t5, hold} = '0;
    ce = 1'b1;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    cap(16'h0000);
    chk({31'h0, flag}, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, TCU_OFS_CONTROL, {27'h0, 1'(i / 2), (i % 2) ? TCU_MODE_RISE : TCU_MODE_FALL});
      pulse(1'b0);
      exp_v = tsel_cnt(1'(i / 2));
      cap(exp_v);
      chk({31'h0, flag}, 32'h1);
    end
    bus(1'b1, TCU_OFS_FLAG, 32'h0);
    @(posedge clock);
    chk({31'h0, flag}, 32'h0);
    // frozen unit must not see a pad pulse
    ce <= 1'b0;
    pulse(1'b0);
    ce <= 1'b1;
    @(posedge clock);
    chk({31'h0, flag}, 32'h0);
    bus(1'b1, TCU_OFS_CONTROL, 32'h0);
    pulse(1'b0);
    cap(exp_v);
    for (int m = 6; m < 8; m++) begin
      bus(1'b1, TCU_OFS_CONTROL, 32'h0);
      bus(1'b1, TCU_OFS_CONTROL, 32'(m));
      for (int k = 1; k <= edges(4'(m)); k++) begin
        pulse(1'b0);
        if (k == edges(4'(m))) exp_v = t1;
        cap(exp_v);
      end
    end
    bus(1'b1, TCU_OFS_CONTROL, 32'h0);
    bus(1'b1, TCU_OFS_CONTROL, {28'h0, TCU_MODE_RISE16});
    repeat (3) pulse(1'b0);
    bus(1'b1, TCU_OFS_CONTROL, {28'h0, TCU_MODE_RISE4});
    pulse(1'b0);
    exp_v = t1;
    cap(exp_v);
    bus(1'b1, TCU_OFS_ALT_PIN, 32'h1);
    bus(1'b1, TCU_OFS_CONTROL, {28'h0, TCU_MODE_RISE});
    pulse(1'b0);
    cap(exp_v);
    sleep <= 1'b1;
    ext <= 1'b1;
    pulse(1'b1);
    cap(t1);
    chk({31'h0, run_en}, 32'h1);
    ext <= 1'b0;
    @(posedge clock);
    chk({31'h0, run_en}, 32'h0);
    bus(1'b1, TCU_OFS_ENABLE, 32'h1);
    @(posedge clock);
    chk({31'h0, ien}, 32'h1);
    give_verdict;
  end
endmodule
`default_nettype wire
